// File: hw/potm_group.sv
// One four-bit pattern output group with its port data bits
`timescale 1ns/1ns
`default_nettype none
module potm_group
    import potm_pkg::*;
#(
    parameter int WIDTH = 4
) (
    input  wire logic             pclk,         // Bus clock
    input  wire logic             presetn,      // Async reset, active low
    input  wire logic             port_wr,      // Software write of port data
    input  wire logic [WIDTH-1:0] port_wdata,   // Port data write value
    input  wire logic             trig_a,       // Selected compare-match A
    input  wire logic             trig_b,       // Selected compare-match B
    input  wire logic             nonoverlap,   // Non-overlap mode
    input  wire logic [WIDTH-1:0] next_data,    // Next pattern data
    input  wire logic [WIDTH-1:0] next_enable,  // Next pattern enable
    output logic      [WIDTH-1:0] pattern_q     // Port data bits driven out
);
    logic [WIDTH-1:0] pattern_nxt;
    logic [WIDTH-1:0] clear_mask;

    always_comb begin
        pattern_nxt = pattern_q;
        clear_mask  = next_enable & ~next_data;
        if (port_wr) begin
            pattern_nxt = port_wdata;
        end
        if (trig_a) begin
            // Enabled bits copy next data, others hold
            pattern_nxt = (next_data & next_enable) | (pattern_nxt & ~next_enable);
        end else if (trig_b && nonoverlap) begin
            // Only zeros move on match B
            pattern_nxt = pattern_nxt & ~clear_mask;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pattern_q <= '0;
        end else begin
            pattern_q <= pattern_nxt;
        end
    end
endmodule
`default_nettype wire

// File: hw/potm_pkg.sv
// Constants for the pattern output trigger and mode control block
package potm_pkg;
    localparam int          POTM_NUM_GROUPS      = 4;
    localparam int          POTM_GROUP_BITS      = 4;
    localparam int          POTM_NUM_CHANNELS    = 4;
    localparam int          POTM_PINS            = POTM_NUM_GROUPS * POTM_GROUP_BITS;
    localparam int          POTM_SEL_BITS        = 2;
    localparam int          POTM_ADDR_BITS       = 12;
    // Byte offsets of the register words
    localparam logic [11:0] POTM_OFS_TRIG_SEL    = 12'h000;
    localparam logic [11:0] POTM_OFS_OUT_MODE    = 12'h004;
    localparam logic [11:0] POTM_OFS_PORT_DATA   = 12'h008;
    // Reset values
    localparam logic [7:0]  POTM_TRIG_SEL_RST    = 8'hFF;
    localparam logic [7:0]  POTM_OUT_MODE_RST    = 8'hF0;
    localparam logic [3:0]  POTM_MODE_FIXED_ONES = 4'hF;
    localparam logic [15:0] POTM_PORT_DATA_RST   = 16'h0000;
    // Field positions: group g selects with bits [2g+1:2g], mode bit g
    localparam int          POTM_MODE_LSB        = 0;
    localparam int          POTM_MODE_FIXED_LSB  = 4;
    localparam int          POTM_GRP3_SEL_LSB    = 6;
    localparam int          POTM_GRP2_SEL_LSB    = 4;
    localparam int          POTM_GRP1_SEL_LSB    = 2;
    localparam int          POTM_GRP0_SEL_LSB    = 0;
endpackage

// File: hw/potm_top.sv
// Trigger select and output mode control of the timing pattern unit
//
// Function
// - The trigger select register is 8-bit read/write, resets to all ones, survives standby.
// - Bits 7:6 of trigger select pick timer channel 0 to 3 for group 3 (pins 15 to 12).
// - Bits 5:4 of trigger select pick the timer channel for group 2 (pins 11 to 8).
// - Bits 3:2 of trigger select pick the timer channel for group 1 (pins 7 to 4).
// - Bits 1:0 of trigger select pick the timer channel for group 0 (pins 3 to 0).
// - The output mode register is 8 bits, resets to 0xF0, survives standby.
// - Output mode bits 7 to 4 always read as one and software writes ones there.
// - Output mode bits 3 to 0 choose ordinary (0) or non-overlap (1) for groups 3 to 0.
// - In ordinary mode a group updates only on match A of its selected channel.
// - In non-overlap mode ones and zeros are timed separately by match A and match B.
// - On a trigger each enabled bit copies next data, disabled bits hold their value.
// - In non-overlap mode match A transfers all enabled bits, match B only zero bits.
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module potm_top
    import potm_pkg::*;
#(
    parameter int NUM_GROUPS = POTM_NUM_GROUPS,
    parameter int GROUP_BITS = POTM_GROUP_BITS
) (
    input  wire logic                      pclk,                  // Bus clock, 25 MHz
    input  wire logic                      presetn,               // Async reset, active low
    input  wire logic                      psel,                  // APB select
    input  wire logic                      penable,               // APB enable
    input  wire logic                      pwrite,                // APB direction
    input  wire logic [POTM_ADDR_BITS-1:0] paddr,                 // APB byte address
    input  wire logic [31:0]               pwdata,                // APB write data
    output logic      [31:0]               prdata,                // APB read data
    output logic                           pready,                // APB ready
    output logic                           pslverr,               // APB error
    input  wire logic [3:0]                match_a,               // Match A strobes, ch 3..0
    input  wire logic [3:0]                match_b,               // Match B strobes, ch 3..0
    input  wire logic [POTM_PINS-1:0]      next_pattern_data,     // Next data bits
    input  wire logic [POTM_PINS-1:0]      next_pattern_enable,   // Next data enables
    output logic      [POTM_PINS-1:0]      port_b_data_reg        // Pattern pin values
);
    logic [7:0]             pattern_trigger_select_r;
    logic [3:0]             pattern_output_mode_r;
    logic [31:0]            prdata_r;
    logic                   pslverr_r;
    logic                   setup_ph;
    logic                   access_ph;
    logic                   wr_trig_sel;
    logic                   wr_out_mode;
    logic                   wr_port;
    logic [NUM_GROUPS-1:0]  grp_trig_a;
    logic [NUM_GROUPS-1:0]  grp_trig_b;
    logic [7:0]             out_mode_view;

    // Picks one channel strobe by a two-bit selection
    function automatic logic pick_strobe(input logic [1:0] sel, input logic [3:0] strobes);
        pick_strobe = strobes[sel];
    endfunction

    // Register decode for one address
    function automatic logic hit(input logic [POTM_ADDR_BITS-1:0] a,
                                 input logic [POTM_ADDR_BITS-1:0] ofs);
        hit = (a == ofs);
    endfunction

    assign setup_ph      = psel && !penable;
    assign access_ph     = psel && penable;
    assign pready        = 1'b1;
    assign prdata        = prdata_r;
    assign pslverr       = pslverr_r && access_ph;
    assign wr_trig_sel   = access_ph && pwrite && hit(paddr, POTM_OFS_TRIG_SEL);
    assign wr_out_mode   = access_ph && pwrite && hit(paddr, POTM_OFS_OUT_MODE);
    assign wr_port       = access_ph && pwrite && hit(paddr, POTM_OFS_PORT_DATA);
    assign out_mode_view = {POTM_MODE_FIXED_ONES, pattern_output_mode_r};

    // Trigger select register, no standby clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pattern_trigger_select_r <= POTM_TRIG_SEL_RST;
        end else if (wr_trig_sel) begin
            pattern_trigger_select_r <= pwdata[7:0];
        end
    end

    // Output mode register, upper bits fixed at one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pattern_output_mode_r <= POTM_OUT_MODE_RST[3:0];
        end else if (wr_out_mode) begin
            pattern_output_mode_r <= pwdata[3:0];
        end
    end

    // Read data latched in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= '0;
            pslverr_r <= 1'b0;
        end else if (setup_ph) begin
            prdata_r  <= '0;
            pslverr_r <= 1'b0;
            if (hit(paddr, POTM_OFS_TRIG_SEL)) begin
                prdata_r[7:0] <= pattern_trigger_select_r;
            end else if (hit(paddr, POTM_OFS_OUT_MODE)) begin
                prdata_r[7:0] <= out_mode_view;
            end else if (hit(paddr, POTM_OFS_PORT_DATA)) begin
                prdata_r[POTM_PINS-1:0] <= port_b_data_reg;
            end else begin
                pslverr_r <= 1'b1;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_GROUPS; g++) begin : gen_grp
            localparam int LO = g * GROUP_BITS;
            // Per-group channel routing
            assign grp_trig_a[g] = pick_strobe(pattern_trigger_select_r[2*g +: 2],
                                               match_a);
            assign grp_trig_b[g] = pick_strobe(pattern_trigger_select_r[2*g +: 2],
                                               match_b);
            potm_group #(
                .WIDTH       (GROUP_BITS)
            ) u_group (
                .pclk        (pclk),
                .presetn     (presetn),
                .port_wr     (wr_port),
                .port_wdata  (pwdata[LO +: GROUP_BITS]),
                .trig_a      (grp_trig_a[g]),
                .trig_b      (grp_trig_b[g]),
                .nonoverlap  (pattern_output_mode_r[g]),
                .next_data   (next_pattern_data[LO +: GROUP_BITS]),
                .next_enable (next_pattern_enable[LO +: GROUP_BITS]),
                .pattern_q   (port_b_data_reg[LO +: GROUP_BITS])
            );
        end
    endgenerate

    // Checks
    logic [POTM_PINS-1:0] exp_copy;
    logic [POTM_PINS-1:0] exp_zero;
    assign exp_copy = (next_pattern_data & next_pattern_enable)
                    | (port_b_data_reg & ~next_pattern_enable);
    assign exp_zero = port_b_data_reg & ~(next_pattern_enable & ~next_pattern_data);

    // Channel choice taken straight from the register fields
    logic [1:0]           grp3_chan_sel;
    logic [1:0]           grp2_chan_sel;
    logic [1:0]           grp1_chan_sel;
    logic [1:0]           grp0_chan_sel;
    logic [3:0]           sel_match_a;
    logic [3:0]           sel_match_b;
    assign grp3_chan_sel = pattern_trigger_select_r[POTM_GRP3_SEL_LSB +: POTM_SEL_BITS];
    assign grp2_chan_sel = pattern_trigger_select_r[POTM_GRP2_SEL_LSB +: POTM_SEL_BITS];
    assign grp1_chan_sel = pattern_trigger_select_r[POTM_GRP1_SEL_LSB +: POTM_SEL_BITS];
    assign grp0_chan_sel = pattern_trigger_select_r[POTM_GRP0_SEL_LSB +: POTM_SEL_BITS];
    assign sel_match_a = {match_a[grp3_chan_sel], match_a[grp2_chan_sel],
                          match_a[grp1_chan_sel], match_a[grp0_chan_sel]};
    assign sel_match_b = {match_b[grp3_chan_sel], match_b[grp2_chan_sel],
                          match_b[grp1_chan_sel], match_b[grp0_chan_sel]};

    a_reset_values: assert property (@(posedge pclk)
        $rose(presetn) |-> pattern_trigger_select_r == POTM_TRIG_SEL_RST
                        && out_mode_view == POTM_OUT_MODE_RST)
        else $error("register reset values wrong");

    a_trig_sel_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_trig_sel |=> pattern_trigger_select_r == $past(pwdata[7:0]))
        else $error("trigger select write lost");

    a_mode_readback: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_ph && !pwrite && hit(paddr, POTM_OFS_OUT_MODE))
        |=> prdata[7:4] == 4'hF && prdata[3:0] == $past(pattern_output_mode_r))
        else $error("output mode readback wrong");

    a_grp3_route: assert property (@(posedge pclk) disable iff (!presetn)
        (match_a[pattern_trigger_select_r[7:6]] && !wr_port)
        |=> port_b_data_reg[15:12] == $past(exp_copy[15:12]))
        else $error("group 3 trigger routing wrong");

    a_grp2_route: assert property (@(posedge pclk) disable iff (!presetn)
        (match_a[pattern_trigger_select_r[5:4]] && !wr_port)
        |=> port_b_data_reg[11:8] == $past(exp_copy[11:8]))
        else $error("group 2 trigger routing wrong");

    a_grp1_route: assert property (@(posedge pclk) disable iff (!presetn)
        (match_a[pattern_trigger_select_r[3:2]] && !wr_port)
        |=> port_b_data_reg[7:4] == $past(exp_copy[7:4]))
        else $error("group 1 trigger routing wrong");

    a_grp0_route: assert property (@(posedge pclk) disable iff (!presetn)
        (match_a[pattern_trigger_select_r[1:0]] && !wr_port)
        |=> port_b_data_reg[3:0] == $past(exp_copy[3:0]))
        else $error("group 0 trigger routing wrong");

    a_ordinary_ignores_b: assert property (@(posedge pclk) disable iff (!presetn)
        (!pattern_output_mode_r[1] && !grp_trig_a[1] && !wr_port)
        |=> $stable(port_b_data_reg[7:4]))
        else $error("ordinary group changed without match A");

    a_nonov_b_zeros: assert property (@(posedge pclk) disable iff (!presetn)
        (pattern_output_mode_r[0] && grp_trig_b[0] && !grp_trig_a[0] && !wr_port)
        |=> port_b_data_reg[3:0] == $past(exp_zero[3:0]))
        else $error("non-overlap match B transfer wrong");

    a_disabled_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !wr_port |=> ((port_b_data_reg ^ $past(port_b_data_reg))
                      & ~$past(next_pattern_enable)) == '0)
        else $error("disabled bit changed");

    a_group_isolation: assert property (@(posedge pclk) disable iff (!presetn)
        (!grp_trig_a[3] && !grp_trig_b[3] && !wr_port) |=> $stable(port_b_data_reg[15:12]))
        else $error("group 3 moved on another group's trigger");

    // Register access
    a_trig_sel_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !wr_trig_sel |=> $stable(pattern_trigger_select_r))
        else $error("trigger select changed without a write");

    a_trig_sel_readback: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_ph && !pwrite && hit(paddr, POTM_OFS_TRIG_SEL))
        |=> prdata == {24'h00_0000, $past(pattern_trigger_select_r)})
        else $error("trigger select readback wrong");

    a_mode_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_out_mode |=> pattern_output_mode_r == $past(pwdata[3:0]))
        else $error("output mode write lost");

    a_mode_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !wr_out_mode |=> $stable(pattern_output_mode_r))
        else $error("output mode changed without a write");

    a_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_ph && !hit(paddr, POTM_OFS_TRIG_SEL) && !hit(paddr, POTM_OFS_OUT_MODE)
            && !hit(paddr, POTM_OFS_PORT_DATA))
        |=> pslverr && prdata == '0)
        else $error("unmapped access not refused");

    a_mapped_no_error: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_ph && (hit(paddr, POTM_OFS_TRIG_SEL) || hit(paddr, POTM_OFS_OUT_MODE)
            || hit(paddr, POTM_OFS_PORT_DATA)))
        |=> !pslverr)
        else $error("mapped access flagged as error");

    a_reset_outputs: assert property (@(posedge pclk)
        $rose(presetn) |-> port_b_data_reg == POTM_PORT_DATA_RST
                        && prdata == '0 && !pslverr)
        else $error("outputs not at reset values");

    a_port_readback: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_ph && !pwrite && hit(paddr, POTM_OFS_PORT_DATA))
        |=> prdata == {16'h0000, $past(port_b_data_reg)})
        else $error("port data readback wrong");

    a_port_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_port && sel_match_a == 4'h0 && sel_match_b == 4'h0)
        |=> port_b_data_reg == $past(pwdata[15:0]))
        else $error("port data write lost");

    // Non-overlap zero transfers on the routed match B, and match A winning when both arrive
    a_grp1_b_zeros: assert property (@(posedge pclk) disable iff (!presetn)
        (pattern_output_mode_r[1] && sel_match_b[1] && !sel_match_a[1] && !wr_port)
        |=> port_b_data_reg[7:4] == $past(exp_zero[7:4]))
        else $error("group 1 match B transfer wrong");

    a_grp2_b_zeros: assert property (@(posedge pclk) disable iff (!presetn)
        (pattern_output_mode_r[2] && sel_match_b[2] && !sel_match_a[2] && !wr_port)
        |=> port_b_data_reg[11:8] == $past(exp_zero[11:8]))
        else $error("group 2 match B transfer wrong");

    a_grp3_b_zeros: assert property (@(posedge pclk) disable iff (!presetn)
        (pattern_output_mode_r[3] && sel_match_b[3] && !sel_match_a[3] && !wr_port)
        |=> port_b_data_reg[15:12] == $past(exp_zero[15:12]))
        else $error("group 3 match B transfer wrong");

    a_match_a_wins: assert property (@(posedge pclk) disable iff (!presetn)
        (pattern_output_mode_r[1] && sel_match_a[1] && sel_match_b[1] && !wr_port)
        |=> port_b_data_reg[7:4] == $past(exp_copy[7:4]))
        else $error("group 1 match A lost to match B");

    // Ordinary groups hold without their match A
    a_grp0_ord_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (!pattern_output_mode_r[0] && !sel_match_a[0] && !wr_port)
        |=> $stable(port_b_data_reg[3:0]))
        else $error("ordinary group 0 moved without match A");

    a_grp2_ord_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (!pattern_output_mode_r[2] && !sel_match_a[2] && !wr_port)
        |=> $stable(port_b_data_reg[11:8]))
        else $error("ordinary group 2 moved without match A");

    a_grp3_ord_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (!pattern_output_mode_r[3] && !sel_match_a[3] && !wr_port)
        |=> $stable(port_b_data_reg[15:12]))
        else $error("ordinary group 3 moved without match A");

    a_all_ordinary_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (pattern_output_mode_r == 4'h0 && sel_match_a == 4'h0 && !wr_port)
        |=> $stable(port_b_data_reg))
        else $error("ordinary port moved on match B");

    // Groups ignore triggers routed to other groups
    a_grp0_isolation: assert property (@(posedge pclk) disable iff (!presetn)
        (!sel_match_a[0] && !sel_match_b[0] && !wr_port)
        |=> $stable(port_b_data_reg[3:0]))
        else $error("group 0 moved on another group's trigger");

    a_grp1_isolation: assert property (@(posedge pclk) disable iff (!presetn)
        (!sel_match_a[1] && !sel_match_b[1] && !wr_port)
        |=> $stable(port_b_data_reg[7:4]))
        else $error("group 1 moved on another group's trigger");

    a_grp2_isolation: assert property (@(posedge pclk) disable iff (!presetn)
        (!sel_match_a[2] && !sel_match_b[2] && !wr_port)
        |=> $stable(port_b_data_reg[11:8]))
        else $error("group 2 moved on another group's trigger");

    // Ones appear only on match A
    a_grp0_rise_on_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!sel_match_a[0] && !wr_port)
        |=> (port_b_data_reg[3:0] & ~$past(port_b_data_reg[3:0])) == 4'h0)
        else $error("group 0 bit rose without match A");

    a_grp1_rise_on_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!sel_match_a[1] && !wr_port)
        |=> (port_b_data_reg[7:4] & ~$past(port_b_data_reg[7:4])) == 4'h0)
        else $error("group 1 bit rose without match A");

    a_grp2_rise_on_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!sel_match_a[2] && !wr_port)
        |=> (port_b_data_reg[11:8] & ~$past(port_b_data_reg[11:8])) == 4'h0)
        else $error("group 2 bit rose without match A");

    a_grp3_rise_on_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!sel_match_a[3] && !wr_port)
        |=> (port_b_data_reg[15:12] & ~$past(port_b_data_reg[15:12])) == 4'h0)
        else $error("group 3 bit rose without match A");

    c_nonov_b_then_a: cover property (@(posedge pclk) disable iff (!presetn)
        pattern_output_mode_r[2] && grp_trig_b[2] ##[1:20] grp_trig_a[2]);

    c_shared_channel: cover property (@(posedge pclk) disable iff (!presetn)
        grp_trig_a == 4'hF && next_pattern_enable != '0);

    c_split_channels: cover property (@(posedge pclk) disable iff (!presetn)
        grp_trig_a[0] && !grp_trig_a[3]);

    c_slave_error: cover property (@(posedge pclk) disable iff (!presetn)
        pslverr);

    c_a_with_b: cover property (@(posedge pclk) disable iff (!presetn)
        pattern_output_mode_r[1] && grp_trig_a[1] && grp_trig_b[1]);
endmodule
`default_nettype wire

// File: verif/potm_timer_model.sv
// Timer channel model issuing compare-match strobes
`timescale 1ns/1ns
`default_nettype none
module potm_timer_model (
    input  wire logic       pclk,     // Bus clock
    output logic      [3:0] match_a,  // Match A strobes, ch 3..0
    output logic      [3:0] match_b   // Match B strobes, ch 3..0
);
    initial begin
        match_a = 4'h0;
        match_b = 4'h0;
    end

    // Quiet for dly+1 cycles, then one-clock strobes
    task automatic strobe(input logic [3:0] a, input logic [3:0] b, input int dly);
        repeat (dly) @(posedge pclk);
        @(posedge pclk);
        match_a <= a;
        match_b <= b;
        @(posedge pclk);
        match_a <= 4'h0;
        match_b <= 4'h0;
    endtask
endmodule
`default_nettype wire

// File: verif/potm_top_tb.sv
// Self-checking testbench for the pattern trigger and mode block
`timescale 1ns/1ns
`default_nettype none
module potm_top_tb
    import potm_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  match_a, match_b;
    logic [15:0] next_pattern_data, next_pattern_enable, port_b_data_reg, exp_q;
    int          error_cnt = 0;
    int          total_checks = 0;

    potm_top potm_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .match_a, .match_b, .next_pattern_data,
        .next_pattern_enable, .port_b_data_reg);
    potm_timer_model potm_timer_model_inst (.pclk, .match_a, .match_b);

    task automatic test_done;
        if (error_cnt == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic fire(input logic [3:0] a, b, input logic [15:0] d, e, want);
        @(posedge pclk);
        next_pattern_data <= d;
        next_pattern_enable <= e;
        potm_timer_model_inst.strobe(a, b, 1);
        @(posedge pclk);
        #1;
        check("pins", 32'(port_b_data_reg), 32'(want));
    endtask

    task automatic t_reset;
        apb(1'b0, POTM_OFS_TRIG_SEL, 32'h0000_0000);
        check("trig_sel", rd, 32'h0000_00FF);
        check("pslverr", 32'(err), 32'h0000_0000);
        check("pready", 32'(pready), 32'h0000_0001);
        apb(1'b0, POTM_OFS_OUT_MODE, 32'h0000_0000);
        check("out_mode", rd, 32'h0000_00F0);
        check("pins", 32'(port_b_data_reg), 32'h0000_0000);
    endtask

    task automatic t_regs;
        apb(1'b1, POTM_OFS_TRIG_SEL, 32'h0000_001B);
        apb(1'b0, POTM_OFS_TRIG_SEL, 32'h0000_0000);
        check("trig_sel", rd, 32'h0000_001B);
        apb(1'b1, POTM_OFS_OUT_MODE, 32'h0000_0005);
        apb(1'b0, POTM_OFS_OUT_MODE, 32'h0000_0000);
        check("out_mode", rd, 32'h0000_00F5);
        apb(1'b1, POTM_OFS_OUT_MODE, 32'h0000_00F0);
        apb(1'b0, POTM_OFS_OUT_MODE, 32'h0000_0000);
        check("out_mode", rd, 32'h0000_00F0);
        apb(1'b1, 12'h00C, 32'h0000_00FF);
        check("pslverr", 32'(err), 32'h0000_0001);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        check("unmapped", rd, 32'h0000_0000);
    endtask

    // Every group sees every channel code; only the chosen group moves
    task automatic t_select;
        logic [7:0]  sel;
        logic [15:0] d;
        int          g;
        for (int r = 0; r < 4; r++) begin
            for (int k = 0; k < 4; k++) sel[2*k +: 2] = 2'(k + r);
            apb(1'b1, POTM_OFS_TRIG_SEL, {24'h00_0000, sel});
            for (int c = 0; c < 4; c++) begin
                g = (c - r) & 3;
                exp_q[4*g +: 4] = ~exp_q[4*g +: 4];
                d = ~exp_q ^ (16'h000F << (4 * g));
                fire(4'(1 << c), 4'h0, d, 16'hFFFF, exp_q);
            end
        end
        fire(4'h0, 4'hF, ~exp_q, 16'hFFFF, exp_q);
    endtask

    task automatic t_enable;
        logic [15:0] d;
        d = ~exp_q;
        exp_q = exp_q ^ 16'h0F3C;
        fire(4'hF, 4'h0, d, 16'h0F3C, exp_q);
    endtask

    // Match B on the period, match A after the gap
    task automatic t_nonoverlap;
        apb(1'b1, POTM_OFS_TRIG_SEL, 32'h0000_00E4);
        apb(1'b1, POTM_OFS_OUT_MODE, 32'h0000_00F5);
        apb(1'b1, POTM_OFS_PORT_DATA, 32'h0000_FFFF);
        apb(1'b0, POTM_OFS_PORT_DATA, 32'h0000_0000);
        check("port_data", rd, 32'h0000_FFFF);
        fire(4'h0, 4'hF, 16'h5A3C, 16'hFFFF, 16'hFAFC);
        fire(4'hF, 4'h0, 16'h5A3C, 16'hFFFF, 16'h5A3C);
        apb(1'b1, POTM_OFS_OUT_MODE, 32'h0000_00FA);
        fire(4'h0, 4'hF, 16'h0000, 16'hFFFF, 16'h0A0C);
        fire(4'hF, 4'hF, 16'h3C5A, 16'hFFFF, 16'h3C5A);
        exp_q = 16'h3C5A;
    endtask

    task automatic t_rereset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        exp_q = 16'h0000;
        t_reset;
    endtask

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    initial begin
        #400_000;
        error_cnt++;
        test_done;
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        next_pattern_data = 16'h0000;
        next_pattern_enable = 16'h0000;
        exp_q = 16'h0000;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_regs;
        t_select;
        t_enable;
        t_nonoverlap;
        t_rereset;
        test_done;
    end
endmodule
`default_nettype wire
